// >>> common/pmsr_consts.svh
// Offsets, field positions, reset values and counts of the mode and soft reset register
`ifndef PMSR_CONSTS_SVH
`define PMSR_CONSTS_SVH
`define PMSR_REG_OFF 8'h14
`define PMSR_SRST_BIT 15
`define PMSR_RSV_HI_MSB 14
`define PMSR_RSV_HI_LSB 7
`define PMSR_MEDIA_BIT 6
`define PMSR_RSV_MID_MSB 5
`define PMSR_RSV_MID_LSB 4
`define PMSR_RSV_B3_BIT 3
`define PMSR_MODE_MSB 2
`define PMSR_MODE_LSB 0
`define PMSR_RSV_HI_RST 8'h04
`define PMSR_RSV_MID_RST 2'h0
`define PMSR_RSV_B3_RST 1'h0
`define PMSR_MEDIA_RST 1'h0
`define PMSR_MODE_RST 3'h0
`define PMSR_SRST_CYCLES 16
`define PMSR_STRAP_WAIT 2'h2
`endif

// >>> common/pmsr_pkg.sv
// Types of the mode and soft reset register block
package pmsr_pkg;
	// Operating mode codes of the three-bit mode field
	typedef enum logic [2:0] {
		PMSR_QSGMII_COPPER = 3'h0,
		PMSR_SGMII_COPPER = 3'h1,
		PMSR_QSGMII_1000BX = 3'h2,
		PMSR_QSGMII_FX_AUTO = 3'h3
	} pmsr_mode_type;

	// Whole state of the register block
	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [1:0] strap_cnt;
		logic strap_done;
		logic srst;
		logic [7:0] rsv_hi;
		logic media_sel;
		logic [1:0] rsv_mid;
		logic rsv_b3;
		logic [2:0] mode_reg;
		logic [2:0] act_mode;
		logic act_media;
		logic page6_rst;
		logic page18_rst;
		logic sys_sgmii;
		logic media_copper;
		logic media_1000bx;
		logic media_100fx;
		logic media_auto;
		logic mode_rsvd;
		logic [15:0] rdata;
	} pmsr_top_state_type;

	// State of the reset sequencer
	typedef struct packed {
		logic busy;
		logic [15:0] cnt;
	} pmsr_seq_state_type;
endpackage : pmsr_pkg

// >>> common/pmsr_seq_if.sv
// Handshake between the register block and its reset sequencer
`timescale 1ns/1ps
interface pmsr_seq_if;
	logic start;
	logic busy;
	logic done;
	modport ctrl (output start, input busy, input done);
	modport seq (input start, output busy, output done);
endinterface : pmsr_seq_if

// >>> hdl/pmsr_reset_seq.sv
// Counter that times one software reset operation
`timescale 1ns/1ps
`include "pmsr_consts.svh"
module pmsr_reset_seq #(
	parameter int CYCLES = `PMSR_SRST_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Link to the register block
	pmsr_seq_if.seq sq
);
	pmsr_pkg::pmsr_seq_state_type st_q; // Registered state
	pmsr_pkg::pmsr_seq_state_type st_d; // Next state

	// Done in the last busy cycle, so the owner clears its flag on the next edge
	assign sq.busy = st_q.busy;
	assign sq.done = st_q.busy && (st_q.cnt == 16'h0000);

	// Start reloads the count, even in the done cycle, so a fresh request is never lost
	always_comb begin
		st_d = st_q;
		if (sq.start) begin
			st_d.busy = 1'b1;
			st_d.cnt = 16'(CYCLES - 1);
		end else if (st_q.busy) begin
			if (st_q.cnt == 16'h0000) begin
				st_d.busy = 1'b0;
			end else begin
				st_d.cnt = st_q.cnt - 16'h0001;
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule : pmsr_reset_seq

// >>> hdl/pmsr_top.sv
// Global mode select and self-clearing software reset register
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "pmsr_consts.svh"
module pmsr_top #(
	parameter int ADDR_W = 8,
	parameter int SRST_CYCLES = `PMSR_SRST_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	// Mode strap pins, asynchronous
	input wire logic [2:0] mode_pins,
	// Soft reset of the register groups
	output logic page6_rst,
	output logic page18_rst,
	// Applied operating mode
	output logic [2:0] active_mode,
	output logic active_media_sel,
	output logic sys_sgmii,
	output logic media_copper,
	output logic media_1000bx,
	output logic media_100fx,
	output logic media_auto,
	output logic mode_rsvd
);
	localparam int SRST_LAST = SRST_CYCLES - 1; // Cycles the bit stands after its rise, less the last one
	localparam logic [ADDR_W-1:0] REG_OFF = ADDR_W'(`PMSR_REG_OFF); // Register address

	pmsr_pkg::pmsr_top_state_type st_q; // Registered state
	pmsr_pkg::pmsr_top_state_type st_d; // Next state
	pmsr_seq_if sq (); // Link to the sequencer
	logic hit_wr; // Write to this register
	logic hit_rd; // Read of this register
	logic [15:0] image; // Register as software sees it

	// Sequencer that times the reset
	pmsr_reset_seq #(
		.CYCLES(SRST_CYCLES)
	) u_seq (
		.clk(clk),
		.rstn(rstn),
		.sq(sq)
	);

	// Address decode
	// One register lives here, so a single compare is enough
	always_comb begin
		hit_wr = 1'b0;
		hit_rd = 1'b0;
		if (addr == REG_OFF) begin
			hit_wr = wr;
			hit_rd = rd;
		end
	end

	// Read image with the reset bit showing the ongoing operation
	assign image = {st_q.srst, st_q.rsv_hi, st_q.media_sel, st_q.rsv_mid, st_q.rsv_b3, st_q.mode_reg};

	// A new request is taken when idle or in the very cycle the old one ends
	// A request in mid-operation is dropped; software sees bit 15 still set and may retry
	assign sq.start = hit_wr && wdata[`PMSR_SRST_BIT] && (!st_q.srst || sq.done);

	// Next state
	always_comb begin
		st_d = st_q;
		// Strap synchroniser, second stage only is read
		st_d.sync1 = mode_pins;
		st_d.sync2 = st_q.sync1;
		// Plain read and write fields; software keeps reserved bits as read
		if (hit_wr) begin
			st_d.rsv_hi = wdata[`PMSR_RSV_HI_MSB:`PMSR_RSV_HI_LSB];
			st_d.media_sel = wdata[`PMSR_MEDIA_BIT];
			st_d.rsv_mid = wdata[`PMSR_RSV_MID_MSB:`PMSR_RSV_MID_LSB];
			st_d.rsv_b3 = wdata[`PMSR_RSV_B3_BIT];
			st_d.mode_reg = wdata[`PMSR_MODE_MSB:`PMSR_MODE_LSB];
		end
		// Wait for the synchroniser to fill after reset release, then load once
		// Placed after the write, so the strap level wins over a write in the load cycle
		if (!st_q.strap_done) begin
			if (st_q.strap_cnt == `PMSR_STRAP_WAIT) begin
				st_d.strap_done = 1'b1;
				st_d.mode_reg = st_q.sync2;
				st_d.act_mode = st_q.sync2;
			end else begin
				st_d.strap_cnt = st_q.strap_cnt + 2'h1;
			end
		end
		// Self clearing reset bit, a new start wins over the end of the old one
		if (sq.start) begin
			st_d.srst = 1'b1;
			// Mode is disruptive, so it is only taken on at reset
			st_d.act_mode = st_d.mode_reg;
			st_d.act_media = st_d.media_sel;
		end else if (sq.done) begin
			st_d.srst = 1'b0;
		end
		// Both register groups follow the reset bit
		st_d.page6_rst = st_d.srst;
		st_d.page18_rst = st_d.srst;
		// Decode the applied mode straight into output flops
		st_d.sys_sgmii = 1'b0;
		st_d.media_copper = 1'b0;
		st_d.media_1000bx = 1'b0;
		st_d.media_100fx = 1'b0;
		st_d.media_auto = 1'b0;
		st_d.mode_rsvd = 1'b0;
		case (st_d.act_mode)
			pmsr_pkg::PMSR_QSGMII_COPPER: begin
				st_d.media_copper = 1'b1;
			end
			pmsr_pkg::PMSR_SGMII_COPPER: begin
				st_d.sys_sgmii = 1'b1;
				st_d.media_copper = 1'b1;
			end
			pmsr_pkg::PMSR_QSGMII_1000BX: begin
				st_d.media_1000bx = 1'b1;
			end
			pmsr_pkg::PMSR_QSGMII_FX_AUTO: begin
				// Fibre only, or auto detection between copper and fibre
				st_d.media_100fx = !st_d.act_media;
				st_d.media_auto = st_d.act_media;
			end
			default: begin
				// Reserved codes leave every media path off
				st_d.mode_rsvd = 1'b1;
			end
		endcase
		// Read data stand one cycle; unmapped reads give zero
		st_d.rdata = hit_rd ? image : 16'h0000;
	end

	// State register; straps are caught after release, not under reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
			st_q.rsv_hi <= `PMSR_RSV_HI_RST;
			st_q.rsv_mid <= `PMSR_RSV_MID_RST;
			st_q.rsv_b3 <= `PMSR_RSV_B3_RST;
			st_q.media_sel <= `PMSR_MEDIA_RST;
			st_q.mode_reg <= `PMSR_MODE_RST;
			st_q.act_mode <= `PMSR_MODE_RST;
			st_q.media_copper <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flops
	assign rdata = st_q.rdata;
	assign page6_rst = st_q.page6_rst;
	assign page18_rst = st_q.page18_rst;
	assign active_mode = st_q.act_mode;
	assign active_media_sel = st_q.act_media;
	assign sys_sgmii = st_q.sys_sgmii;
	assign media_copper = st_q.media_copper;
	assign media_1000bx = st_q.media_1000bx;
	assign media_100fx = st_q.media_100fx;
	assign media_auto = st_q.media_auto;
	assign mode_rsvd = st_q.mode_rsvd;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	chk_srst_start: assert property (hit_wr && wdata[15] && !st_q.srst |=> st_q.srst && page6_rst)
		else $error("software reset did not start at once");
	chk_srst_selfclr: assert property ($rose(st_q.srst) |-> ##(SRST_LAST) st_q.srst ##1 (!st_q.srst || $past(sq.start)))
		else $error("reset bit did not clear after the operation");
	chk_pages_follow: assert property ($rose(page6_rst) |-> page18_rst && $past(sq.start))
		else $error("register groups not reset together");
	chk_strap_load: assert property ($rose(st_q.strap_done) |-> st_q.mode_reg == $past(st_q.sync2))
		else $error("mode field not loaded from straps");
	chk_mode_hold: assert property ($past(st_q.strap_done) && !$past(sq.start) |-> $stable(active_mode))
		else $error("mode applied without software reset");
	chk_mode_apply: assert property (sq.start |=> active_mode == st_q.mode_reg ##1 media_1000bx == (active_mode == 3'h2))
		else $error("mode not applied at software reset");
	chk_mode_decode: assert property (active_mode == 3'h1 |-> sys_sgmii && media_copper && !mode_rsvd)
		else $error("mode decode wrong");
	chk_fx_select: assert property (active_mode == 3'h3 |-> media_100fx == !active_media_sel && media_auto == active_media_sel)
		else $error("fibre or auto media choice wrong");

	// Sequencer and register flag move together, and a read shows the flag
	chk_busy_match: assert property (st_q.srst == sq.busy)
		else $error("reset bit and sequencer disagree");
	chk_read_bit: assert property (hit_rd |=> rdata[`PMSR_SRST_BIT] == $past(st_q.srst))
		else $error("read data do not show the reset bit");
	// A request in the last busy cycle restarts, any earlier one is refused
	chk_restart_done: assert property (hit_wr && wdata[`PMSR_SRST_BIT] && sq.done |=>
		st_q.srst && page6_rst)
		else $error("reset request in the last busy cycle lost");
	chk_refuse_hold: assert property (hit_wr && st_q.srst && !sq.done && st_q.strap_done |=>
		st_q.srst && $stable(active_mode) && $stable(active_media_sel))
		else $error("mode applied by a refused reset request");
	// Decode outputs agree with the applied code in modes 0 and 4 to 7; system side and fibre flags stay in their own modes
	chk_copper_decode: assert property (active_mode == 3'h0 |->
		media_copper && !sys_sgmii && !media_1000bx && !mode_rsvd)
		else $error("copper mode decode wrong");
	chk_rsvd_decode: assert property (active_mode[2] |->
		mode_rsvd && !sys_sgmii && !media_copper && !media_1000bx && !media_100fx && !media_auto)
		else $error("reserved mode drives a media path");
	chk_sgmii_only: assert property (sys_sgmii |-> active_mode == 3'h1)
		else $error("system side choice outside its mode");
	chk_fx_only: assert property (media_100fx || media_auto |-> active_mode == 3'h3)
		else $error("fibre media outside its mode");
	// Both groups share one reset, and the straps pass two flops first
	chk_pages_equal: assert property (page6_rst == page18_rst && page18_rst == st_q.srst)
		else $error("register group resets differ");
	chk_sync_chain: assert property (st_q.sync2 == $past(st_q.sync1))
		else $error("strap synchroniser skipped a stage");
endmodule : pmsr_top

// >>> test/pmsr_top_test.sv
// Self-checking bench of the mode select and soft reset register
`timescale 1ns/1ps
`include "pmsr_consts.svh"
module pmsr_top_test;
	localparam int SRST = 4; // Short soft reset run keeps the sim brief
	localparam logic [7:0] REG = `PMSR_REG_OFF;
	// Design ports
	logic clk, rstn, wr, rd;
	logic [7:0] addr;
	logic [15:0] wdata, rdata;
	logic [2:0] mode_pins, active_mode;
	logic page6_rst, page18_rst, active_media_sel, sys_sgmii, media_copper;
	logic media_1000bx, media_100fx, media_auto, mode_rsvd;
	// Bench state
	logic [15:0] got; // Last read word
	logic [31:0] seed; // Random source
	logic [2:0] md, cur; // Written and applied mode
	logic m6, cur6; // Written and applied media bit
	int errors, total_checks;
	// All applied-mode outputs in one vector for comparing
	wire logic [11:0] act_out = {page6_rst, page18_rst, active_mode, active_media_sel,
		sys_sgmii, media_copper, media_1000bx, media_100fx, media_auto, mode_rsvd};

	// Device under test
	pmsr_top #(.ADDR_W(8), .SRST_CYCLES(SRST)) pmsr_top_i (.clk(clk), .rstn(rstn), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .mode_pins(mode_pins), .page6_rst(page6_rst),
		.page18_rst(page18_rst), .active_mode(active_mode), .active_media_sel(active_media_sel),
		.sys_sgmii(sys_sgmii), .media_copper(media_copper), .media_1000bx(media_1000bx),
		.media_100fx(media_100fx), .media_auto(media_auto), .mode_rsvd(mode_rsvd));

	// Free running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Next value of the random sequence
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		lfsr = {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
	endfunction : lfsr

	// Register word; reserved bits carry their reset values
	function automatic logic [15:0] img(input logic s, input logic b6, input logic [2:0] m);
		img = {s, 8'h04, b6, 3'h0, m};
	endfunction : img

	// Expected outputs: page resets, applied mode and its decode
	function automatic logic [11:0] outs(input logic r, input logic b6, input logic [2:0] m);
		logic [5:0] dec;
		dec = m[2] ? 6'h01 : m == 3'h0 ? 6'h10 : m == 3'h1 ? 6'h30 : m == 3'h2 ? 6'h08 : (b6 ? 6'h02 : 6'h04);
		outs = {r, r, m, b6, dec};
	endfunction : outs

	// Compare a register word
	task automatic chk_reg(input logic [15:0] exp, input logic [15:0] act);
		total_checks++;
		if (act !== exp) begin
			errors++;
			$display("unexpected word at %0t: got %h expected %h", $time, act, exp);
		end
	endtask : chk_reg

	// Compare the applied-mode outputs
	task automatic chk_out(input logic [11:0] exp, input logic [11:0] act);
		total_checks++;
		if (act !== exp) begin
			errors++;
			$display("unexpected outputs at %0t: got %h expected %h", $time, act, exp);
		end
	endtask : chk_out

	// One-cycle write strobe
	task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : reg_wr

	// One-cycle read strobe; data taken in the following cycle only
	task automatic reg_rd(input logic [7:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		got = rdata;
	endtask : reg_rd

	// Hardware reset with a given strap level, then check the loaded mode
	task automatic hw_reset(input logic [2:0] s);
		@(posedge clk);
		rstn <= 1'b0;
		mode_pins <= s;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk_out(outs(1'b0, 1'b0, s), act_out);
		reg_rd(REG);
		chk_reg(img(1'b0, 1'b0, s), got);
		cur = s;
		cur6 = 1'b0;
	endtask : hw_reset

	// Print counts and verdict, then stop
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#50000;
		errors++;
		end_sim();
	end

	// Main sequence
	initial begin
		{rstn, wr, rd, addr, wdata, mode_pins} = '0;
		errors = 0;
		total_checks = 0;
		seed = 32'hD038;
		hw_reset(3'h5);
		$display("test strap_load done");
		// Unmapped place: write ignored, read gives zero
		reg_wr(8'h15, 16'hFFFF);
		reg_rd(8'h15);
		chk_reg(16'h0000, got);
		reg_rd(REG);
		chk_reg(img(1'b0, 1'b0, 3'h5), got);
		$display("test unmapped done");
		// Every code with both media bits, then random ones
		for (int i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			md = (i < 16) ? i[2:0] : seed[2:0];
			m6 = (i < 16) ? i[3] : seed[9];
			// Mode written alone is stored but not applied
			reg_wr(REG, img(1'b0, m6, md));
			chk_out(outs(1'b0, cur6, cur), act_out);
			reg_rd(REG);
			chk_reg(img(1'b0, m6, md), got);
			// Soft reset starts at once and applies the new mode
			reg_wr(REG, img(1'b1, m6, md));
			chk_out(outs(1'b1, m6, md), act_out);
			reg_rd(REG);
			chk_reg(img(1'b1, m6, md), got);
			repeat (SRST - 2) @(posedge clk);
			#1;
			chk_out(outs(1'b0, m6, md), act_out);
			reg_rd(REG);
			chk_reg(img(1'b0, m6, md), got);
			cur = md;
			cur6 = m6;
		end
		$display("test mode_and_reset done");
		// Corner cases: a request while busy is refused, one in the last busy cycle restarts
		reg_wr(REG, img(1'b1, 1'b0, 3'h2));
		reg_wr(REG, img(1'b1, 1'b1, 3'h3));
		chk_out(outs(1'b1, 1'b0, 3'h2), act_out);
		repeat (SRST - 4) @(posedge clk);
		reg_wr(REG, img(1'b1, 1'b1, 3'h3));
		chk_out(outs(1'b1, 1'b1, 3'h3), act_out);
		repeat (SRST - 1) @(posedge clk);
		#1;
		chk_out(outs(1'b1, 1'b1, 3'h3), act_out);
		@(posedge clk);
		#1;
		chk_out(outs(1'b0, 1'b1, 3'h3), act_out);
		$display("test corner_cases done");
		// Second hardware reset mid-run with a random strap
		seed = lfsr(seed);
		hw_reset(seed[2:0]);
		$display("test strap_reload done");
		end_sim();
	end
endmodule : pmsr_top_test
